// *** hdl/pswb_regs.svh ***
// Purpose: offsets, field positions, reset values and timing counts of the switch/buck config slice
// Assumes: byte-wide subaddressed register access from the serial interface
// Notes: definitions only
`ifndef PSWB_REGS_SVH
`define PSWB_REGS_SVH

`define PSWB_ADDR_LS_CFG 8'h15
`define PSWB_ADDR_BUCK_A 8'h16
`define PSWB_ADDR_BUCK_B 8'h17

`define PSWB_RST_LS_CFG 8'h00
`define PSWB_RST_BUCK 8'h99

`define PSWB_LS_CUT_LSB 3
`define PSWB_LS_DCHG_LSB 0
`define PSWB_LS_WMASK 8'h3F
`define PSWB_BUCK_WMASK 8'hBF
`define PSWB_BUCK_SKIP_BIT 7
`define PSWB_BUCK_RSVD_BIT 6
`define PSWB_VSEL_MSB 5

`define PSWB_VSEL_KNEE 6'h32
`define PSWB_MV_BASE 11'h352
`define PSWB_MV_KNEE 11'h546
`define PSWB_MV_FINE_STEP 11'h00A
`define PSWB_MV_COARSE_STEP 11'h019

`define PSWB_CLK_KHZ 25000
`define PSWB_BLANK_US 5000
`define PSWB_BLANK_CYCLES ((`PSWB_BLANK_US * `PSWB_CLK_KHZ) / 1000)

`endif

// *** hdl/pswb_pkg.sv ***
// Purpose: shared types of the switch/buck config slice
// Assumes: constants live in pswb_regs.svh
// Notes: none
package pswb_pkg;
	typedef logic [7:0] pswb_byte_t;
	typedef logic [5:0] pswb_vsel_t;
	typedef logic [10:0] pswb_mv_t;
	typedef logic [2:0] pswb_sw_t;
	typedef enum logic [0:0] {
		PSWB_BLANK_IDLE = 1'b0,
		PSWB_BLANK_ACTIVE = 1'b1
	} pswb_blank_e;
endpackage : pswb_pkg

// *** hdl/pswb_ls_if.sv ***
// Purpose: bundle between the config slice and one load switch controller
// Assumes: single clock domain
// Notes: none
`timescale 1ns/100ps
interface pswb_ls_if;
	logic sw_en;
	logic powerfail_cut;
	logic discharge_en;
	logic powerfail_out_n;
	logic sw_on;
	logic discharge_on;
	modport ctrl (input sw_en, input powerfail_cut, input discharge_en, input powerfail_out_n,
		output sw_on, output discharge_on);
	modport owner (output sw_en, output powerfail_cut, output discharge_en, output powerfail_out_n,
		input sw_on, input discharge_on);
endinterface : pswb_ls_if

// *** hdl/pswb_ls_ctrl.sv ***
// Purpose: on/off and active discharge control of one load switch
// Assumes: powerfail_out_n synchronous to the clock
// Notes: outputs registered, one cycle after their cause
`timescale 1ns/100ps
module pswb_ls_ctrl (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// switch bundle
	pswb_ls_if.ctrl ls
);
	import pswb_pkg::*;

	logic next_on;
	logic next_discharge;

	// comparator trip only matters when the cut bit is set
	assign next_on = ls.sw_en & ~(ls.powerfail_cut & ~ls.powerfail_out_n);
	assign next_discharge = ls.discharge_en & ~next_on;

	always_ff @(posedge clk) begin
		if (rst) begin
			ls.sw_on <= 1'b0;
			ls.discharge_on <= 1'b0;
		end else begin
			ls.sw_on <= next_on;
			ls.discharge_on <= next_discharge;
		end
	end

	property p_cut_off;
		@(posedge clk) disable iff (rst)
		(ls.powerfail_cut && !ls.powerfail_out_n) |=> !ls.sw_on;
	endproperty
	a_cut_off: assert property (p_cut_off) else $error("switch on during power fail with cut set");

	property p_no_cut;
		@(posedge clk) disable iff (rst)
		!ls.powerfail_cut |=> (ls.sw_on == $past(ls.sw_en));
	endproperty
	a_no_cut: assert property (p_no_cut) else $error("switch state disturbed without cut bit");

	property p_discharge_on;
		@(posedge clk) disable iff (rst)
		(ls.discharge_en && !ls.sw_en) |=> (ls.discharge_on && !ls.sw_on);
	endproperty
	a_discharge_on: assert property (p_discharge_on) else $error("off switch not discharged");

	property p_discharge_off;
		@(posedge clk) disable iff (rst)
		(!ls.discharge_en || next_on) |=> !ls.discharge_on;
	endproperty
	a_discharge_off: assert property (p_discharge_off) else $error("discharge applied when not allowed");
endmodule : pswb_ls_ctrl

// *** hdl/pswb_blank_timer.sv ***
// Purpose: retriggerable supervisor blanking window
// Assumes: start is a one-cycle pulse
// Notes: a new start restarts the full window
`timescale 1ns/100ps
module pswb_blank_timer #(
	parameter int CYCLES = 125000
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic start,
	output logic blank
);
	import pswb_pkg::*;

	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	pswb_blank_e state;
	pswb_blank_e next_state;
	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic done;

	assign done = (count == LAST);

	always_comb begin
		next_state = state;
		next_count = count;
		case (state)
			PSWB_BLANK_IDLE: begin
				if (start) begin
					next_state = PSWB_BLANK_ACTIVE;
					next_count = '0;
				end
			end
			PSWB_BLANK_ACTIVE: begin
				if (start) begin
					next_count = '0;
				end else if (done) begin
					next_state = PSWB_BLANK_IDLE;
				end else begin
					next_count = count + CW'(1);
				end
			end
			default: begin
				next_state = PSWB_BLANK_IDLE;
				next_count = '0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= PSWB_BLANK_IDLE;
			count <= '0;
		end else begin
			state <= next_state;
			count <= next_count;
		end
	end

	assign blank = (state == PSWB_BLANK_ACTIVE);

	property p_window_len;
		@(posedge clk) disable iff (rst)
		(blank && !start && done) |=> !blank;
	endproperty
	a_window_len: assert property (p_window_len) else $error("blanking did not end at its count");

	property p_window_hold;
		@(posedge clk) disable iff (rst)
		(blank && !done) |=> blank;
	endproperty
	a_window_hold: assert property (p_window_hold) else $error("blanking ended early");
endmodule : pswb_blank_timer

// *** hdl/pswb_cfg_top.sv ***
// Purpose: load switch power-fail/discharge config and core buck mode/voltage registers
// Assumes: serial interface decodes subaddress and strobes; password logic gives REG_UNLOCKED
// Notes: voltage codes are staged and only reach the bucks on an apply pulse
//
// Behaviour
// - cut bit set: power fail turns switch off
// - cut bit clear: power fail ignored
// - discharge bit set: off switch is discharged
// - discharge bit clear: never discharge
// - switch config at 0x15, resets zero
// - writes need unlock, otherwise rejected
// - buck write blanks supervision for 5 ms
// - voltage applied only on go/go-disable
// - bit 7 selects pulse skip or PWM
// - buck A at 0x16, resets 0x99
// - buck B at 0x17, resets 0x99
// - six-bit code: 10 mV then 25 mV steps
`timescale 1ns/100ps
`include "pswb_regs.svh"
module pswb_cfg_top #(
	parameter int BLANK_CYCLES = `PSWB_BLANK_CYCLES
) (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	// register access from the serial interface
	input wire pswb_pkg::pswb_byte_t REG_ADDR,
	input wire pswb_pkg::pswb_byte_t REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic REG_UNLOCKED,
	output pswb_pkg::pswb_byte_t REG_RDATA,
	output logic REG_WR_REJECT,
	// go bits of the apply register
	input wire logic VOLTAGE_APPLY_GO,
	input wire logic VOLTAGE_APPLY_DISABLE,
	// load switches
	input wire pswb_pkg::pswb_sw_t LS_EN,
	input wire logic POWERFAIL_OUT_N,
	output pswb_pkg::pswb_sw_t LS_ON,
	output pswb_pkg::pswb_sw_t LS_DISCHARGE,
	// core bucks
	output logic BUCK_A_PULSE_SKIP_EN,
	output pswb_pkg::pswb_vsel_t BUCK_A_VSEL,
	output pswb_pkg::pswb_mv_t BUCK_A_MV,
	output logic BUCK_B_PULSE_SKIP_EN,
	output pswb_pkg::pswb_vsel_t BUCK_B_VSEL,
	output pswb_pkg::pswb_mv_t BUCK_B_MV,
	// supervisor
	output logic SUPV_BLANK
);
	import pswb_pkg::*;

	pswb_byte_t ls_cfg;
	pswb_byte_t buck_a;
	pswb_byte_t buck_b;

	// piecewise code to millivolts
	function automatic pswb_mv_t vsel_to_mv(input pswb_vsel_t code);
		pswb_mv_t wide;
		wide = 11'(code);
		if (code <= `PSWB_VSEL_KNEE) begin
			vsel_to_mv = `PSWB_MV_BASE + wide * `PSWB_MV_FINE_STEP;
		end else begin
			vsel_to_mv = `PSWB_MV_KNEE + (wide - 11'(`PSWB_VSEL_KNEE)) * `PSWB_MV_COARSE_STEP;
		end
	endfunction : vsel_to_mv

	// address decode
	wire hit_ls = (REG_ADDR == `PSWB_ADDR_LS_CFG);
	wire hit_a = (REG_ADDR == `PSWB_ADDR_BUCK_A);
	wire hit_b = (REG_ADDR == `PSWB_ADDR_BUCK_B);
	wire hit_any = hit_ls | hit_a | hit_b;

	// writes without unlock leave every register untouched
	wire wr_ok = REG_WR & REG_UNLOCKED;
	wire wr_ls = wr_ok & hit_ls;
	wire wr_a = wr_ok & hit_a;
	wire wr_b = wr_ok & hit_b;
	wire wr_bad = REG_WR & hit_any & ~REG_UNLOCKED;
	wire apply = VOLTAGE_APPLY_GO | VOLTAGE_APPLY_DISABLE;

	// reserved positions never store a one
	wire [7:0] wdata_ls = REG_WDATA & `PSWB_LS_WMASK;
	wire [7:0] wdata_buck = REG_WDATA & `PSWB_BUCK_WMASK;

	wire [7:0] rd_mux = hit_ls ? ls_cfg :
		hit_a ? buck_a :
		hit_b ? buck_b : 8'h00;

	wire pswb_vsel_t stage_a = buck_a[`PSWB_VSEL_MSB:0];
	wire pswb_vsel_t stage_b = buck_b[`PSWB_VSEL_MSB:0];

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			ls_cfg <= `PSWB_RST_LS_CFG;
		end else if (wr_ls) begin
			ls_cfg <= wdata_ls;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			buck_a <= `PSWB_RST_BUCK;
		end else if (wr_a) begin
			buck_a <= wdata_buck;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			buck_b <= `PSWB_RST_BUCK;
		end else if (wr_b) begin
			buck_b <= wdata_buck;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			REG_RDATA <= 8'h00;
			REG_WR_REJECT <= 1'b0;
		end else begin
			if (REG_RD) begin
				REG_RDATA <= rd_mux;
			end
			REG_WR_REJECT <= wr_bad;
		end
	end

	// mode follows the register; only the voltage waits for apply
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			BUCK_A_PULSE_SKIP_EN <= 1'(`PSWB_RST_BUCK >> `PSWB_BUCK_SKIP_BIT);
			BUCK_B_PULSE_SKIP_EN <= 1'(`PSWB_RST_BUCK >> `PSWB_BUCK_SKIP_BIT);
		end else begin
			BUCK_A_PULSE_SKIP_EN <= buck_a[`PSWB_BUCK_SKIP_BIT];
			BUCK_B_PULSE_SKIP_EN <= buck_b[`PSWB_BUCK_SKIP_BIT];
		end
	end

	// apply pulse in the write cycle still sees the old staged code
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			BUCK_A_VSEL <= 6'(`PSWB_RST_BUCK);
			BUCK_B_VSEL <= 6'(`PSWB_RST_BUCK);
			BUCK_A_MV <= vsel_to_mv(6'(`PSWB_RST_BUCK));
			BUCK_B_MV <= vsel_to_mv(6'(`PSWB_RST_BUCK));
		end else if (apply) begin
			BUCK_A_VSEL <= stage_a;
			BUCK_B_VSEL <= stage_b;
			BUCK_A_MV <= vsel_to_mv(stage_a);
			BUCK_B_MV <= vsel_to_mv(stage_b);
		end
	end

	// load switches
	pswb_ls_if ls_bus[3] ();

	for (genvar i = 0; i < 3; i++) begin : g_ls
		assign ls_bus[i].sw_en = LS_EN[i];
		assign ls_bus[i].powerfail_cut = ls_cfg[`PSWB_LS_CUT_LSB + i];
		assign ls_bus[i].discharge_en = ls_cfg[`PSWB_LS_DCHG_LSB + i];
		assign ls_bus[i].powerfail_out_n = POWERFAIL_OUT_N;
		assign LS_ON[i] = ls_bus[i].sw_on;
		assign LS_DISCHARGE[i] = ls_bus[i].discharge_on;
		pswb_ls_ctrl u_ls (
			.clk(SYS_CLK),
			.rst(SYS_RST),
			.ls(ls_bus[i])
		);
	end

	// both bucks share one supervisor window
	logic blank_start;
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			blank_start <= 1'b0;
		end else begin
			blank_start <= wr_a | wr_b;
		end
	end

	pswb_blank_timer #(
		.CYCLES(BLANK_CYCLES)
	) u_blank (
		.clk(SYS_CLK),
		.rst(SYS_RST),
		.start(blank_start),
		.blank(SUPV_BLANK)
	);

	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (SYS_RST);

	sequence s_buck_write;
		REG_WR && REG_UNLOCKED && (hit_a || hit_b);
	endsequence

	sequence s_blank_starts;
		##2 SUPV_BLANK [*8];
	endsequence

	property p_reset_vals;
		$past(SYS_RST) |-> (ls_cfg == 8'h00 && buck_a == 8'h99 && buck_b == 8'h99);
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("register reset value wrong");

	property p_buck_reset;
		$past(SYS_RST) |-> (BUCK_A_VSEL == 6'h19 && BUCK_B_VSEL == 6'h19 && BUCK_A_PULSE_SKIP_EN);
	endproperty
	a_buck_reset: assert property (p_buck_reset) else $error("buck outputs wrong after reset");

	property p_reject;
		(REG_WR && hit_any && !REG_UNLOCKED) |=> (REG_WR_REJECT && $stable(ls_cfg) && $stable(buck_a)
			&& $stable(buck_b));
	endproperty
	a_reject: assert property (p_reject) else $error("locked write not rejected");

	property p_blank;
		s_buck_write |-> s_blank_starts;
	endproperty
	a_blank: assert property (p_blank) else $error("buck write did not blank supervision");

	property p_hold_vsel;
		!apply |=> ($stable(BUCK_A_VSEL) && $stable(BUCK_B_VSEL));
	endproperty
	a_hold_vsel: assert property (p_hold_vsel) else $error("voltage changed without apply");

	property p_apply_vsel;
		(REG_WR && REG_UNLOCKED && hit_b && !apply) ##1 (!REG_WR && !apply) ##1 apply
			|=> (BUCK_B_VSEL == $past(REG_WDATA[5:0], 3));
	endproperty
	a_apply_vsel: assert property (p_apply_vsel) else $error("applied code differs from written");

	property p_skip;
		(REG_WR && REG_UNLOCKED && hit_a) |-> ##2 (BUCK_A_PULSE_SKIP_EN == $past(REG_WDATA[7], 2));
	endproperty
	a_skip: assert property (p_skip) else $error("pulse skip mode does not follow bit 7");

	property p_mv_knee;
		(BUCK_A_VSEL == 6'h32) |-> (BUCK_A_MV == 11'h546);
	endproperty
	a_mv_knee: assert property (p_mv_knee) else $error("knee code not 1350 mV");

	property p_mv_top;
		(BUCK_B_VSEL == 6'h3F) |-> (BUCK_B_MV == 11'h68B);
	endproperty
	a_mv_top: assert property (p_mv_top) else $error("top code not 1675 mV");

	property p_reserved;
		REG_RD |=> (REG_RDATA[7:6] == 2'h0 || !$past(hit_ls)) && (REG_RDATA[6] == 1'b0);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit read as one");
endmodule : pswb_cfg_top

// *** sim/pswb_host_model.sv ***
// Purpose: host side of the register port and apply strobes
// Assumes: strobes change at the falling edge, one-cycle pulses
// Notes: address and data lines idle at the inverse of the last value
`timescale 1ns/100ps
module pswb_host_model (
	// clock
	input wire logic clk,
	// register port
	output pswb_pkg::pswb_byte_t addr,
	output pswb_pkg::pswb_byte_t wdata,
	output logic wr,
	output logic rd,
	output logic unlocked,
	input wire pswb_pkg::pswb_byte_t rdata,
	// apply strobes
	output logic go,
	output logic go_dis
);
	import pswb_pkg::*;

	initial begin
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		unlocked = 1'b0;
		go = 1'b0;
		go_dis = 1'b0;
	end

	task automatic write(input pswb_byte_t a, input pswb_byte_t d, input logic unl);
		@(negedge clk);
		addr = a;
		wdata = d;
		unlocked = unl;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
		unlocked = 1'b0;
		addr = ~addr;
		wdata = ~wdata;
	endtask : write

	task automatic read(input pswb_byte_t a, output pswb_byte_t d);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		d = rdata;
		addr = ~addr;
	endtask : read

	// go and go-disable both commit staged codes
	task automatic apply(input logic use_dis);
		@(negedge clk);
		go = ~use_dis;
		go_dis = use_dis;
		@(negedge clk);
		go = 1'b0;
		go_dis = 1'b0;
	endtask : apply
endmodule : pswb_host_model

// *** sim/pswb_cfg_top_test.sv ***
// Purpose: self-checking bench of the switch/buck config slice
// Assumes: blanking window shortened to 20 cycles
// Notes: all stimulus at the falling edge
`timescale 1ns/100ps
`include "pswb_regs.svh"
module pswb_cfg_top_test;
	import pswb_pkg::*;
	logic SYS_CLK;
	logic SYS_RST;
	pswb_byte_t REG_ADDR, REG_WDATA, REG_RDATA;
	logic REG_WR, REG_RD, REG_UNLOCKED, REG_WR_REJECT, VOLTAGE_APPLY_GO, VOLTAGE_APPLY_DISABLE;
	pswb_sw_t LS_EN, LS_ON, LS_DISCHARGE;
	logic POWERFAIL_OUT_N, BUCK_A_PULSE_SKIP_EN, BUCK_B_PULSE_SKIP_EN, SUPV_BLANK;
	pswb_vsel_t BUCK_A_VSEL, BUCK_B_VSEL;
	pswb_mv_t BUCK_A_MV, BUCK_B_MV;
	int err_count = 0;
	int samples_checked = 0;
	pswb_vsel_t codes[4] = '{6'h00, 6'h32, 6'h33, 6'h3F};
	pswb_mv_t mvs[4] = '{11'h352, 11'h546, 11'h55F, 11'h68B};

	pswb_cfg_top #(.BLANK_CYCLES(20)) dut_u (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
		.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_UNLOCKED(REG_UNLOCKED),
		.REG_RDATA(REG_RDATA), .REG_WR_REJECT(REG_WR_REJECT), .VOLTAGE_APPLY_GO(VOLTAGE_APPLY_GO),
		.VOLTAGE_APPLY_DISABLE(VOLTAGE_APPLY_DISABLE), .LS_EN(LS_EN), .POWERFAIL_OUT_N(POWERFAIL_OUT_N),
		.LS_ON(LS_ON), .LS_DISCHARGE(LS_DISCHARGE), .BUCK_A_PULSE_SKIP_EN(BUCK_A_PULSE_SKIP_EN),
		.BUCK_A_VSEL(BUCK_A_VSEL), .BUCK_A_MV(BUCK_A_MV), .BUCK_B_PULSE_SKIP_EN(BUCK_B_PULSE_SKIP_EN),
		.BUCK_B_VSEL(BUCK_B_VSEL), .BUCK_B_MV(BUCK_B_MV), .SUPV_BLANK(SUPV_BLANK));

	pswb_host_model host_u (.clk(SYS_CLK), .addr(REG_ADDR), .wdata(REG_WDATA), .wr(REG_WR), .rd(REG_RD),
		.unlocked(REG_UNLOCKED), .rdata(REG_RDATA), .go(VOLTAGE_APPLY_GO), .go_dis(VOLTAGE_APPLY_DISABLE));

	initial begin
		SYS_CLK = 1'b0;
		forever #20 SYS_CLK = ~SYS_CLK;
	end

	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic rd_chk(input pswb_byte_t a, input pswb_byte_t exp);
		pswb_byte_t d;
		host_u.read(a, d);
		check("rdata", d, exp);
	endtask : rd_chk

	task automatic settle();
		repeat (2) @(negedge SYS_CLK);
	endtask : settle

	// generous bound: the sequence needs about 105 cycles
	initial begin
		repeat (5000) @(posedge SYS_CLK);
		err_count++;
		results();
	end

	initial begin
		SYS_RST = 1'b1;
		LS_EN = 3'h0;
		POWERFAIL_OUT_N = 1'b1;
		repeat (16) @(negedge SYS_CLK);
		SYS_RST = 1'b0;
		rd_chk(`PSWB_ADDR_LS_CFG, 8'h00);
		rd_chk(`PSWB_ADDR_BUCK_A, 8'h99);
		rd_chk(`PSWB_ADDR_BUCK_B, 8'h99);
		check("vsel_a", BUCK_A_VSEL, 6'h19);
		check("mv_b", BUCK_B_MV, 11'h44C);
		check("skip_b", BUCK_B_PULSE_SKIP_EN, 1'b1);
		host_u.write(`PSWB_ADDR_BUCK_A, 8'h00, 1'b0);
		check("reject", REG_WR_REJECT, 1'b1);
		rd_chk(`PSWB_ADDR_BUCK_A, 8'h99);
		check("blank", SUPV_BLANK, 1'b0);
		host_u.write(8'h18, 8'hFF, 1'b1);
		check("reject", REG_WR_REJECT, 1'b0);
		rd_chk(8'h18, 8'h00);
		host_u.write(`PSWB_ADDR_LS_CFG, 8'hFF, 1'b1);
		rd_chk(`PSWB_ADDR_LS_CFG, 8'h3F);
		// window must run its full length after a buck write
		host_u.write(`PSWB_ADDR_BUCK_A, 8'h7F, 1'b1);
		@(negedge SYS_CLK);
		check("blank", SUPV_BLANK, 1'b1);
		check("skip_a", BUCK_A_PULSE_SKIP_EN, 1'b0);
		check("vsel_a", BUCK_A_VSEL, 6'h19);
		repeat (19) @(negedge SYS_CLK);
		check("blank", SUPV_BLANK, 1'b1);
		@(negedge SYS_CLK);
		check("blank", SUPV_BLANK, 1'b0);
		rd_chk(`PSWB_ADDR_BUCK_A, 8'h3F);
		for (int i = 0; i < 4; i++) begin
			host_u.write(`PSWB_ADDR_BUCK_A, {2'b10, codes[i]}, 1'b1);
			host_u.apply(i[0]);
			check("vsel_a", BUCK_A_VSEL, codes[i]);
			check("mv_a", BUCK_A_MV, mvs[i]);
			check("skip_a", BUCK_A_PULSE_SKIP_EN, 1'b1);
		end
		check("vsel_b", BUCK_B_VSEL, 6'h19);
		host_u.write(`PSWB_ADDR_BUCK_B, 8'h05, 1'b1);
		host_u.apply(1'b1);
		check("mv_b", BUCK_B_MV, 11'h384);
		check("skip_b", BUCK_B_PULSE_SKIP_EN, 1'b0);
		check("vsel_a", BUCK_A_VSEL, 6'h3F);
		LS_EN = 3'h7;
		for (int i = 0; i < 3; i++) begin
			host_u.write(`PSWB_ADDR_LS_CFG, pswb_byte_t'(8'h09 << i), 1'b1);
			POWERFAIL_OUT_N = 1'b0;
			settle();
			check("ls_on", LS_ON, 3'h7 & ~(3'h1 << i));
			check("ls_dis", LS_DISCHARGE, 3'h1 << i);
			POWERFAIL_OUT_N = 1'b1;
			settle();
			check("ls_on", LS_ON, 3'h7);
			check("ls_dis", LS_DISCHARGE, 3'h0);
		end
		host_u.write(`PSWB_ADDR_LS_CFG, 8'h00, 1'b1);
		POWERFAIL_OUT_N = 1'b0;
		LS_EN = 3'h5;
		settle();
		check("ls_on", LS_ON, 3'h5);
		check("ls_dis", LS_DISCHARGE, 3'h0);
		host_u.write(`PSWB_ADDR_LS_CFG, 8'h07, 1'b1);
		settle();
		check("ls_dis", LS_DISCHARGE, 3'h2);
		results();
	end
endmodule : pswb_cfg_top_test
